// >>> ccp_bus_master.sv
// Two-wire bus master and shared control pin driver model
`timescale 1ns/1ns
module ccp_bus_master (
  input wire logic clk,
  input wire logic sdaWire,
  output logic sclOut,
  output logic sdaOut
);
  // Both lines released to the pull-up level at time zero
  initial
  begin
    sclOut = 1'b1;
    sdaOut = 1'b1;
  end
  // Wait n clocks, then step just past the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  // One bit: low 6 clocks, data set early, sampled in high phase
  task automatic bitIo(input logic b, output logic s);
    tick(1);
    sdaOut = b;
    tick(5);
    sclOut = 1'b1;
    tick(1);
    s = sdaWire;
    tick(1);
    sclOut = 1'b0;
  endtask : bitIo
  // Start or repeated start, after any ack has been let go
  task automatic startBus();
    sdaOut = 1'b1;
    tick(6);
    sclOut = 1'b1;
    tick(6);
    sdaOut = 1'b0;
    tick(6);
    sclOut = 1'b0;
  endtask : startBus
  // Stop: data rises while clock high, bus left idle
  task automatic stopBus();
    sdaOut = 1'b0;
    tick(6);
    sclOut = 1'b1;
    tick(6);
    sdaOut = 1'b1;
    tick(6);
  endtask : stopBus
  // Byte out, most significant bit first, returns the ack
  task automatic byteOut(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bitIo(d[i], s);
    bitIo(1'b1, s);
    ack = !s;
  endtask : byteOut
  // Byte in; the last one is answered with a not-acknowledge
  task automatic byteIn(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--)
      bitIo(1'b1, d[i]);
    bitIo(last, s);
  endtask : byteIn
  // Start, address, command, n data bytes; offset 0 never used
  // Ack count stays four-state so an undriven line cannot pass as zero
  task automatic wr(input logic [6:0] a, input logic [7:0] cmd,
                    input logic [15:0] d, input int n,
                    output logic [2:0] acks);
    logic k;
    startBus();
    byteOut({a, 1'b0}, k);
    acks = {2'b00, k};
    byteOut(cmd, k);
    acks = acks + {2'b00, k};
    for (int i = 0; i < n; i++)
    begin
      byteOut(d[15-8*i -: 8], k);
      acks = acks + {2'b00, k};
    end
  endtask : wr
  // Command phase, repeated start, n bytes read, stop
  task automatic rd(input logic [6:0] a, input logic [7:0] cmd,
                    input int n, output logic [31:0] q);
    logic [2:0] acks;
    logic [7:0] b;
    wr(a, cmd, 16'h0, 0, acks);
    startBus();
    byteOut({a, 1'b1}, b[0]);
    q = 32'hffff_ffff;
    for (int i = 0; i < n; i++)
    begin
      byteIn(i == n - 1, b);
      q[31-8*i -: 8] = b;
    end
    stopBus();
  endtask : rd
  // Drive the shared pins as plain control levels
  task automatic setPins(input logic dat, input logic clkPin);
    sdaOut = dat;
    sclOut = clkPin;
  endtask : setPins
endmodule : ccp_bus_master

// >>> ccp_cfg.svh
// Offsets, field positions, reset values and counts of the config port
`ifndef CCP_CFG_SVH
`define CCP_CFG_SVH
// Configuration byte array size and slave address
`define CCP_MEM_BYTES 128
`define CCP_DEV_ADDR_HI 5'b11011
// Generic configuration bytes
`define CCP_OFS_ADDR 7'h01
`define CCP_BIT_BUSY 6
`define CCP_OFS_PINMODE 7'h02
`define CCP_BIT_PINMODE 6
`define CCP_OFS_Y1STATE 7'h02
`define CCP_OFS_Y1SEL 7'h04
`define CCP_OFS_BYTECNT 7'h06
// Per-PLL byte layout, base 10h with a stride of 10h
`define CCP_PLL_BASE 8'h10
`define CCP_PLL_STRIDE 8'h10
`define CCP_PLL_SSC 8'h00
`define CCP_PLL_FS 8'h03
`define CCP_PLL_DOWN 8'h04
`define CCP_PLL_OUTSEL 8'h05
`define CCP_PLL_STATE 8'h06
// Reset values: setting 0 hi-z, setting 1 active, freq 0, spread off
`define CCP_RST_STATES 8'h0d
`define CCP_RST_OUTSEL 8'h02
`define CCP_RST_BYTECNT 8'h40
// EEPROM programming time in clock cycles
`define CCP_NVM_PROG_CYCLES 32'd250000
`endif

// >>> ccp_config_port.sv
// Control pins, two-wire serial slave and config bytes of the synthesizer
//
// Summary of operation
// - Eight stored settings, indexed by three pins
// - Setting gives per-PLL frequency, spread, output select
// - Spread code: off, quarter steps, top is 2%
// - Frequency bit picks programmed frequency zero/one
// - Pair select bit applies state zero/one
// - Single output bit picks generic state zero/one
// - Shared pins serial unless non-volatile bit set
// - Control-pin mode disables serial, supply-off restores
// - First control pin is control only
// - Power-up loads pass-through default configuration
// - Serial mode forces upper index bits low
// - Defaults: setting 0 hi-z, 1 active
// - Two-wire slave, standard and fast, 7-bit
// - Address 11011 plus two programmable low bits
// - Address LSB: one read, zero write
// - Command bit 7 single byte, rest offset
// - Block ascending, MSB first, stop anytime
// - Block read returns byte count bytes
// - Each written byte takes effect at once, except the pin mode bit, which takes effect when programming ends
// - Programming refuses writes, still serves reads
// - Busy bit set during programming, then cleared
`timescale 1ns/1ns
`include "ccp_cfg.svh"
module ccp_config_port
  import ccp_pkg::*;
#(
  parameter int NPLL = 4,
  parameter logic [31:0] NVM_PROG_CYCLES = `CCP_NVM_PROG_CYCLES
)(
  input wire logic clk,
  input wire logic rst,
  input wire logic ctrlPinA,
  input wire logic ctrlPinBSharedDataIn,
  output logic ctrlPinBSharedDataOut,
  output logic ctrlPinBSharedDataOeN,
  input wire logic ctrlPinCSharedClockIn,
  input wire logic outSupplyGrounded,
  input wire logic nvmWriteStart,
  output logic nvmProgramBusy,
  output logic serialActive,
  output logic [NPLL-1:0] pllFreqSel,
  output logic [4*NPLL-1:0] pllSpreadAmt,
  output logic [NPLL-1:0] pllSpreadDown,
  output logic [2*NPLL-1:0] pllPairState,
  output logic [1:0] singleOutState
);
  ////////////////////////////////////////////////////////////////////////////
  // State of the port
  typedef struct packed {
    ccp_state_t st;      // Serial slave state
    logic [2:0] bitCnt;  // Bit or ack phase counter
    logic [7:0] shift;   // Shift register
    logic sclPrev;       // Last accepted clock level
    logic sdaPrev;       // Last accepted data level
    logic drv;           // Pulling data low
    logic ackOk;         // Acknowledge pending phase
    logic isRead;        // Direction of current transfer
    logic single;        // Single byte access
    logic [6:0] ptr;     // Byte offset pointer
    logic [7:0] remain;  // Bytes left in a block read
    logic nvmPin;        // Non-volatile pin mode bit
    logic busy;          // EEPROM programming in progress
    logic [31:0] busyCnt; // Programming cycles left
    ccp_mem_t mem;       // Volatile configuration bytes
  } ccp_port_t;
  ccp_port_t r;
  ccp_port_t n;

  logic [3:0] pinLvl;    // Synchronised pins
  logic scl;             // Accepted serial clock
  logic sda;             // Accepted serial data
  logic supplyOff;       // Accepted supply-grounded level
  logic serialMode;      // Shared pins act as serial bus
  logic [2:0] settingIdx; // Selected control setting
  logic [7:0] rxByte;    // Byte completing on this clock rise

  // Default configuration bytes
  function automatic ccp_mem_t defaultMem();
    ccp_mem_t m;
    logic [6:0] base;
    m = '0;
    m[`CCP_OFS_Y1STATE] = `CCP_RST_STATES;
    m[`CCP_OFS_Y1SEL] = `CCP_RST_OUTSEL;
    m[`CCP_OFS_BYTECNT] = `CCP_RST_BYTECNT;
    for (int p = 0; p < NPLL; p++)
    begin
      base = 7'(`CCP_PLL_BASE + p * `CCP_PLL_STRIDE);
      m[base + 7'(`CCP_PLL_OUTSEL)] = `CCP_RST_OUTSEL;
      m[base + 7'(`CCP_PLL_STATE)] = `CCP_RST_STATES;
    end
    return m;
  endfunction : defaultMem

  // Byte as read back, with the live busy flag merged in
  function automatic logic [7:0] readByte(input ccp_mem_t m,
                                          input logic [6:0] ofs,
                                          input logic bsy);
    logic [7:0] b;
    b = m[ofs];
    if (ofs == `CCP_OFS_ADDR)
      b[`CCP_BIT_BUSY] = bsy;
    return b;
  endfunction : readByte

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: data, clock, first control pin, supply level
  ccp_pin_sync #(
    .W(4),
    .RST_VAL(4'h3)
  ) u_sync (
    .clk(clk),
    .rst(rst),
    .din({outSupplyGrounded, ctrlPinA, ctrlPinCSharedClockIn,
          ctrlPinBSharedDataIn}),
    .dout(pinLvl)
  );

  assign sda = pinLvl[0];
  assign scl = pinLvl[1];
  assign supplyOff = pinLvl[3];
  // Serial unless programmed as pins; grounded supply restores it
  assign serialMode = ~r.nvmPin | supplyOff;
  // Upper bits read as zero in serial mode
  assign settingIdx = serialMode ? {2'b00, pinLvl[2]}
                                 : {scl, sda, pinLvl[2]};
  assign rxByte = {r.shift[6:0], sda};

  ////////////////////////////////////////////////////////////////////////////
  // Setting selection and output controls
  ccp_setting_sel #(
    .NPLL(NPLL)
  ) u_sel (
    .clk(clk),
    .rst(rst),
    .settingIdx(settingIdx),
    .cfgMem(r.mem),
    .pllFreqSel(pllFreqSel),
    .pllSpreadAmt(pllSpreadAmt),
    .pllSpreadDown(pllSpreadDown),
    .pllPairState(pllPairState),
    .singleOutState(singleOutState)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Serial slave, programming timer and configuration bytes
  always_comb
  begin
    logic sclRise;
    logic sclFall;
    logic startC;
    logic stopC;
    sclRise = scl & ~r.sclPrev;
    sclFall = ~scl & r.sclPrev;
    startC = scl & r.sclPrev & r.sdaPrev & ~sda;
    stopC = scl & r.sclPrev & ~r.sdaPrev & sda;
    n = r;
    n.sclPrev = scl;
    n.sdaPrev = sda;
    // Programming cycle copies the pin mode bit when it ends
    if (r.busy)
    begin
      n.busyCnt = r.busyCnt - 32'd1;
      if (r.busyCnt <= 32'd1)
      begin
        n.busy = 1'b0;
        n.nvmPin = r.mem[`CCP_OFS_PINMODE][`CCP_BIT_PINMODE];
      end
    end
    else if (nvmWriteStart)
    begin
      n.busy = 1'b1;
      n.busyCnt = NVM_PROG_CYCLES;
    end
    if (!serialMode)
    begin
      // Serial interface gone while pins act as controls
      n.st = CCP_IDLE;
      n.drv = 1'b0;
    end
    else if (startC)
    begin
      // Start or repeated start opens an address byte
      n.st = CCP_ADDR;
      n.bitCnt = '0;
      n.drv = 1'b0;
    end
    else if (stopC)
    begin
      n.st = CCP_IDLE;
      n.drv = 1'b0;
    end
    else
    begin
      case (r.st)
        CCP_ADDR, CCP_CMD, CCP_WDAT:
        begin
          // Shift in MSB first on clock rise
          if (sclRise)
          begin
            n.shift = rxByte;
            n.bitCnt = r.bitCnt + 3'd1;
            if (r.bitCnt == 3'd7)
            begin
              n.bitCnt = '0;
              if (r.st == CCP_ADDR)
              begin
                // Match 11011 plus low bits
                n.ackOk = (rxByte[7:1] == {`CCP_DEV_ADDR_HI,
                                           r.mem[`CCP_OFS_ADDR][1:0]});
                n.isRead = rxByte[0];
                n.st = CCP_AACK;
              end
              else if (r.st == CCP_CMD)
              begin
                n.single = rxByte[7];
                n.ptr = rxByte[6:0];
                n.ackOk = 1'b1;
                n.st = CCP_CACK;
              end
              else
              begin
                n.ackOk = ~r.busy;
                if (!r.busy)
                begin
                  // Stored now, effective now except the pin mode bit
                  n.mem[r.ptr] = rxByte;
                  if (r.ptr == `CCP_OFS_ADDR)
                    n.mem[r.ptr][`CCP_BIT_BUSY] = 1'b0;
                  n.ptr = r.ptr + 7'd1;
                end
                n.st = CCP_WACK;
              end
            end
          end
        end
        CCP_AACK, CCP_CACK, CCP_WACK:
        begin
          // First fall drives the ack, second fall releases it
          if (sclFall)
          begin
            if (r.bitCnt == 3'd0)
            begin
              n.drv = r.ackOk;
              n.bitCnt = 3'd1;
            end
            else
            begin
              n.drv = 1'b0;
              n.bitCnt = '0;
              if (!r.ackOk)
                n.st = CCP_SKIP;
              else if (r.st == CCP_CACK)
                n.st = CCP_WDAT;
              else if (r.st == CCP_WACK)
                n.st = r.single ? CCP_SKIP : CCP_WDAT;
              else if (r.isRead)
              begin
                // Load first read byte
                n.shift = readByte(r.mem, r.ptr, r.busy);
                n.drv = ~n.shift[7];
                n.ptr = r.ptr + 7'd1;
                n.remain = r.mem[`CCP_OFS_BYTECNT] - 8'd1;
                n.st = CCP_RDAT;
              end
              else
                n.st = CCP_CMD;
            end
          end
        end
        CCP_RDAT:
        begin
          // Shift out MSB first on clock fall
          if (sclFall)
          begin
            n.bitCnt = r.bitCnt + 3'd1;
            n.shift = {r.shift[6:0], 1'b0};
            n.drv = ~r.shift[6];
            if (r.bitCnt == 3'd7)
            begin
              n.bitCnt = '0;
              n.drv = 1'b0;
              n.ackOk = 1'b0;
              n.st = CCP_RACK;
            end
          end
        end
        CCP_RACK:
        begin
          // Master ack on rise; next byte on fall if wanted
          if (sclRise)
            n.ackOk = ~sda;
          if (sclFall)
          begin
            if (!r.ackOk || r.single || r.remain == 8'd0)
              n.st = CCP_SKIP;
            else
            begin
              n.shift = readByte(r.mem, r.ptr, r.busy);
              n.drv = ~n.shift[7];
              n.ptr = r.ptr + 7'd1;
              n.remain = r.remain - 8'd1;
              n.st = CCP_RDAT;
            end
          end
        end
        default: n.drv = 1'b0; // Idle or skipping: released
      endcase
    end
  end

  // Register the state; reset loads the default configuration
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      r <= '0;
      r.st <= CCP_IDLE;
      r.sclPrev <= 1'b1;
      r.sdaPrev <= 1'b1;
      r.mem <= defaultMem();
    end
    else
      r <= n;
  end

  // Open drain data: only ever pulls low
  assign ctrlPinBSharedDataOut = 1'b0;
  assign ctrlPinBSharedDataOeN = ~r.drv;
  assign nvmProgramBusy = r.busy;
  assign serialActive = serialMode;
endmodule : ccp_config_port

// >>> ccp_config_port_checker.sv
// Assertion checker on the config port top ports
`timescale 1ns/1ns
`include "ccp_cfg.svh"
module ccp_config_port_checker
  import ccp_pkg::*;
#(
  parameter int NPLL = 4,
  parameter logic [31:0] NVM_PROG_CYCLES = `CCP_NVM_PROG_CYCLES
)(
  input wire logic clk,
  input wire logic rst,
  input wire logic ctrlPinBSharedDataOut,
  input wire logic ctrlPinBSharedDataOeN,
  input wire logic ctrlPinCSharedClockIn,
  input wire logic outSupplyGrounded,
  input wire logic nvmWriteStart,
  input wire logic nvmProgramBusy,
  input wire logic serialActive,
  input wire logic [4*NPLL-1:0] pllSpreadAmt
);
  // Cycles the busy flag has been high so far
  logic [31:0] busyLen_r;
  // Count the busy run, cleared whenever busy is low
  always_ff @(posedge clk)
  begin
    if (rst || !nvmProgramBusy)
      busyLen_r <= 32'h0;
    else
      busyLen_r <= busyLen_r + 32'h1;
  end
  // Spread nibble may be 0 to 6 quarter steps, or 8
  function automatic logic spreadOk(input logic [4*NPLL-1:0] v);
    spreadOk = 1'b1;
    for (int p = 0; p < NPLL; p++)
      if (v[4*p +: 4] == 4'h7 || v[4*p +: 4] > 4'h8)
        spreadOk = 1'b0;
  endfunction : spreadOk
  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  AST_RST_QUIET: assert property (disable iff (1'b0)
    rst |=> ctrlPinBSharedDataOeN && !nvmProgramBusy && serialActive)
    else $error("outputs not quiet after reset");
  AST_OD_LOW: assert property (
    !ctrlPinBSharedDataOeN |-> !ctrlPinBSharedDataOut)
    else $error("data pin driven high");
  AST_PIN_MODE_QUIET: assert property (
    !serialActive && !$past(serialActive) |-> ctrlPinBSharedDataOeN)
    else $error("data pin driven in control pin mode");
  AST_SUPPLY_SERIAL: assert property (
    outSupplyGrounded [*6] |-> serialActive)
    else $error("grounded supply did not restore serial");
  AST_BUSY_RISE: assert property (
    nvmWriteStart && !nvmProgramBusy |=> nvmProgramBusy)
    else $error("busy not raised by program start");
  AST_BUSY_CAUSE: assert property (
    $rose(nvmProgramBusy) |-> $past(nvmWriteStart))
    else $error("busy raised without program start");
  AST_BUSY_LEN: assert property (
    $fell(nvmProgramBusy) && !$past(rst) |->
      busyLen_r == NVM_PROG_CYCLES)
    else $error("busy length wrong");
  AST_DRIVE_ON_LOW: assert property (
    $changed(ctrlPinBSharedDataOeN) |-> !ctrlPinCSharedClockIn)
    else $error("data pin changed while clock high");
  AST_SPREAD_CODE: assert property (
    spreadOk(pllSpreadAmt))
    else $error("spread amount out of table");
endmodule : ccp_config_port_checker

bind ccp_config_port ccp_config_port_checker #(
  .NPLL(NPLL),
  .NVM_PROG_CYCLES(NVM_PROG_CYCLES)
) u_chk (
  .clk(clk), .rst(rst),
  .ctrlPinBSharedDataOut(ctrlPinBSharedDataOut),
  .ctrlPinBSharedDataOeN(ctrlPinBSharedDataOeN),
  .ctrlPinCSharedClockIn(ctrlPinCSharedClockIn),
  .outSupplyGrounded(outSupplyGrounded),
  .nvmWriteStart(nvmWriteStart), .nvmProgramBusy(nvmProgramBusy),
  .serialActive(serialActive), .pllSpreadAmt(pllSpreadAmt)
);

// >>> ccp_config_port_tb.sv
// Self-checking bench for the config port
`timescale 1ns/1ns
`include "ccp_cfg.svh"
`define CHK(nm, ex, gt) begin nTests++; if ((gt) !== (ex)) begin \
  badCount++; $display("BAD %s exp %0h got %0h", nm, ex, gt); end end
module ccp_config_port_tb
  import ccp_pkg::*;
;
  localparam logic [6:0] DEV = {`CCP_DEV_ADDR_HI, 2'b00};
  logic clk;
  logic rst;
  logic ctrlPinA;
  logic outSupplyGrounded;
  logic nvmWriteStart;
  logic sclM;
  logic sdaM;
  logic sdaOut;
  logic sdaOeN;
  logic busy;
  logic serAct;
  logic [3:0] freqSel;
  logic [15:0] spreadAmt;
  logic [3:0] spreadDown;
  logic [7:0] pairState;
  logic [1:0] singleState;
  int badCount;
  int nTests;
  logic [2:0] acks;
  logic [31:0] q;
  // Open-drain data wire with pull-up
  wire logic sdaLine = sdaM & (sdaOeN | sdaOut);
  ////////////////////////////////////////////////////////////////////////
  ccp_config_port #(.NPLL(4), .NVM_PROG_CYCLES(32'd2000)) dut (
    .clk(clk), .rst(rst), .ctrlPinA(ctrlPinA),
    .ctrlPinBSharedDataIn(sdaLine), .ctrlPinBSharedDataOut(sdaOut),
    .ctrlPinBSharedDataOeN(sdaOeN), .ctrlPinCSharedClockIn(sclM),
    .outSupplyGrounded(outSupplyGrounded), .nvmWriteStart(nvmWriteStart),
    .nvmProgramBusy(busy), .serialActive(serAct), .pllFreqSel(freqSel),
    .pllSpreadAmt(spreadAmt), .pllSpreadDown(spreadDown),
    .pllPairState(pairState), .singleOutState(singleState));
  ccp_bus_master master (.clk(clk), .sdaWire(sdaLine), .sclOut(sclM),
    .sdaOut(sdaM));
  // 50 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  // Write with stop
  task automatic wrs(input logic [7:0] cmd, input logic [15:0] d);
    master.wr(DEV, cmd, d, 1, acks);
    master.stopBus();
    cyc(6);
  endtask : wrs
  task automatic complete_run();
    $display("checks %0d, mismatches %0d", nTests, badCount);
    if (badCount == 0 && nTests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : complete_run
  ////////////////////////////////////////////////////////////////////////
  task automatic tDefaults();
    ctrlPinA = 1'b0;
    cyc(8);
    `CHK("pair", 8'h55, pairState)
    `CHK("single", 2'h1, singleState)
    `CHK("freq", 4'h0, freqSel)
    `CHK("spread", 16'h0, spreadAmt)
    ctrlPinA = 1'b1;
    cyc(8);
    `CHK("pair", 8'hff, pairState)
    `CHK("single", 2'h3, singleState)
    `CHK("serial", 1'b1, serAct)
    $display("test defaults done");
  endtask : tDefaults
  // Wrong address ignored; programmed low address bits obeyed
  task automatic tAddr();
    master.wr({`CCP_DEV_ADDR_HI, 2'b01}, 8'h81, 16'h0200, 1, acks);
    master.stopBus();
    `CHK("nack", 3'd0, acks)
    wrs(8'h81, 16'h0200);
    `CHK("acks", 3'd3, acks)
    master.rd({`CCP_DEV_ADDR_HI, 2'b10}, 8'h81, 1, q);
    `CHK("addr", 8'h02, q[31:24])
    master.wr({`CCP_DEV_ADDR_HI, 2'b10}, 8'h81, 16'h0000, 1, acks);
    master.stopBus();
    `CHK("acks", 3'd3, acks)
    $display("test address done");
  endtask : tAddr
  // Every spread code, checked before the stop
  task automatic tSpread();
    for (int k = 0; k < 8; k++)
    begin
      master.wr(DEV, 8'h90, {2'b00, k[2:0], 11'h0}, 1, acks);
      cyc(6);
      `CHK("spread", k == 7 ? 4'h8 : 4'(k), spreadAmt[3:0])
      master.stopBus();
    end
    $display("test spread done");
  endtask : tSpread
  task automatic tBlock();
    master.wr(DEV, 8'h13, 16'h0201, 2, acks);
    cyc(6);
    `CHK("acks", 3'd4, acks)
    `CHK("freq", 1'b1, freqSel[0])
    `CHK("down", 1'b1, spreadDown[0])
    master.stopBus();
    wrs(8'h86, 16'h0300);
    master.rd(DEV, 8'h13, 4, q);
    `CHK("block", 32'h020102ff, q)
    master.rd(DEV, 8'h93, 2, q);
    `CHK("byte", 32'h02ffffff, q)
    wrs(8'h95, 16'h0000);
    `CHK("pair", 8'hfd, pairState)
    $display("test block done");
  endtask : tBlock
  // Programming, refused write, pin mode, grounded supply, power-up
  task automatic tProgram();
    wrs(8'h82, 16'h4d00);
    `CHK("serial", 1'b1, serAct)
    nvmWriteStart = 1'b1;
    cyc(1);
    nvmWriteStart = 1'b0;
    cyc(1);
    `CHK("busy", 1'b1, busy)
    master.rd(DEV, 8'h81, 1, q);
    `CHK("status", 8'h40, q[31:24])
    wrs(8'h95, 16'h0200);
    `CHK("acks", 3'd2, acks)
    `CHK("pair", 8'hfd, pairState)
    for (int i = 0; i < 3000 && busy !== 1'b0; i++)
      cyc(1);
    if (busy !== 1'b0)
    begin
      badCount++;
      complete_run();
    end
    cyc(2);
    `CHK("serial", 1'b0, serAct)
    master.setPins(1'b1, 1'b1);
    cyc(8);
    `CHK("single", 2'h1, singleState)
    master.setPins(1'b0, 1'b0);
    cyc(8);
    `CHK("single", 2'h3, singleState)
    master.setPins(1'b1, 1'b1);
    outSupplyGrounded = 1'b1;
    cyc(8);
    `CHK("serial", 1'b1, serAct)
    `CHK("single", 2'h3, singleState)
    master.rd(DEV, 8'h86, 1, q);
    `CHK("count", 8'h03, q[31:24])
    outSupplyGrounded = 1'b0;
    cyc(8);
    `CHK("serial", 1'b0, serAct)
    rst = 1'b1;
    cyc(6);
    rst = 1'b0;
    cyc(8);
    `CHK("serial", 1'b1, serAct)
    `CHK("single", 2'h3, singleState)
    $display("test program done");
  endtask : tProgram
  // Main sequence
  initial
  begin
    badCount = 0;
    nTests = 0;
    rst = 1'b1;
    ctrlPinA = 1'b0;
    outSupplyGrounded = 1'b0;
    nvmWriteStart = 1'b0;
    cyc(6);
    rst = 1'b0;
    cyc(4);
    tDefaults();
    tAddr();
    tSpread();
    tBlock();
    tProgram();
    complete_run();
  end
endmodule : ccp_config_port_tb

// >>> ccp_pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
module ccp_pin_sync
  import ccp_pkg::*;
#(
  parameter int W = 4,
  parameter logic [W-1:0] RST_VAL = '1
)(
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  // Stage flops and the accepted level
  typedef struct packed {
    logic [W-1:0] ff1;
    logic [W-1:0] ff2;
    logic [W-1:0] ff3;
    logic [W-1:0] level;
  } ccp_sync_t;
  ccp_sync_t r;
  ccp_sync_t n;

  ////////////////////////////////////////////////////////////////////////////
  // Accept a change only once stages two and three agree
  always_comb
  begin
    n = r;
    n.ff1 = din;
    n.ff2 = r.ff1;
    n.ff3 = r.ff2;
    for (int i = 0; i < W; i++)
    begin
      if (r.ff2[i] == r.ff3[i])
      begin
        n.level[i] = r.ff3[i];
      end
    end
  end

  // Register the stages
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      r <= {RST_VAL, RST_VAL, RST_VAL, RST_VAL};
    end
    else
    begin
      r <= n;
    end
  end

  assign dout = r.level;
endmodule : ccp_pin_sync

// >>> ccp_pkg.sv
// Types shared by the control pin and serial config port
package ccp_pkg;
  // Serial slave states, Gray coded along the usual path
  typedef enum logic [3:0] {
    CCP_IDLE = 4'h0,
    CCP_ADDR = 4'h1,
    CCP_AACK = 4'h3,
    CCP_CMD = 4'h2,
    CCP_CACK = 4'h6,
    CCP_WDAT = 4'h7,
    CCP_WACK = 4'h5,
    CCP_RDAT = 4'h4,
    CCP_RACK = 4'hc,
    CCP_SKIP = 4'hd
  } ccp_state_t;
  // Output state codes held in the state bytes
  typedef enum logic [1:0] {
    CCP_OUT_PDOWN = 2'h0,
    CCP_OUT_HIZ = 2'h1,
    CCP_OUT_LOW = 2'h2,
    CCP_OUT_ACTIVE = 2'h3
  } ccp_outst_t;
  // Volatile configuration byte array
  typedef logic [127:0][7:0] ccp_mem_t;
endpackage : ccp_pkg

// >>> ccp_setting_sel.sv
// Applies one of eight predefined control settings to the PLL controls
`timescale 1ns/1ns
`include "ccp_cfg.svh"
module ccp_setting_sel
  import ccp_pkg::*;
#(
  parameter int NPLL = 4
)(
  input wire logic clk,
  input wire logic rst,
  input wire logic [2:0] settingIdx,
  input wire ccp_mem_t cfgMem,
  output logic [NPLL-1:0] pllFreqSel,
  output logic [4*NPLL-1:0] pllSpreadAmt,
  output logic [NPLL-1:0] pllSpreadDown,
  output logic [2*NPLL-1:0] pllPairState,
  output logic [1:0] singleOutState
);
  // Registered selected controls
  typedef struct packed {
    logic [NPLL-1:0] fs;
    logic [4*NPLL-1:0] amt;
    logic [NPLL-1:0] down;
    logic [2*NPLL-1:0] pair;
    logic [1:0] single;
  } ccp_sel_t;
  ccp_sel_t r;
  ccp_sel_t n;

  // Spread amount in quarter percent steps; top code jumps to 2.0 %
  function automatic logic [3:0] spreadQuarters(input logic [2:0] code);
    spreadQuarters = (code == 3'h7) ? 4'h8 : {1'b0, code};
  endfunction : spreadQuarters

  ////////////////////////////////////////////////////////////////////////////
  // Pick each PLL's fields for the selected setting
  always_comb
  begin
    logic [6:0] base;
    logic [23:0] ssc;
    logic [2:0] code;
    logic [7:0] st;
    base = '0;
    ssc = '0;
    code = '0;
    st = '0;
    n = r;
    for (int p = 0; p < NPLL; p++)
    begin
      base = 7'(`CCP_PLL_BASE + p * `CCP_PLL_STRIDE);
      ssc = {cfgMem[base + 7'(`CCP_PLL_SSC + 2)],
             cfgMem[base + 7'(`CCP_PLL_SSC + 1)],
             cfgMem[base + 7'(`CCP_PLL_SSC)]};
      code = ssc[3 * settingIdx +: 3];
      // Frequency 0 or 1 of this PLL
      n.fs[p] = cfgMem[base + 7'(`CCP_PLL_FS)][settingIdx];
      n.amt[4 * p +: 4] = spreadQuarters(code);
      n.down[p] = cfgMem[base + 7'(`CCP_PLL_DOWN)][0];
      st = cfgMem[base + 7'(`CCP_PLL_STATE)];
      // Pair state 0 or 1 to both outputs
      if (cfgMem[base + 7'(`CCP_PLL_OUTSEL)][settingIdx])
      begin
        n.pair[2 * p +: 2] = st[3:2];
      end
      else
      begin
        n.pair[2 * p +: 2] = st[1:0];
      end
    end
    // Single output from generic states
    st = cfgMem[`CCP_OFS_Y1STATE];
    n.single = cfgMem[`CCP_OFS_Y1SEL][settingIdx] ? st[3:2] : st[1:0];
  end

  // Register the selection
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      r <= '0;
    end
    else
    begin
      r <= n;
    end
  end

  assign pllFreqSel = r.fs;
  assign pllSpreadAmt = r.amt;
  assign pllSpreadDown = r.down;
  assign pllPairState = r.pair;
  assign singleOutState = r.single;
endmodule : ccp_setting_sel
